/* File: core/nrm_region_map.sv */
// Nonvolatile region map, signature words, fetch path and command issue
`timescale 1ns/10ps
module nrm_region_map
   import nrm_pkg::*;
#(
   parameter int VARIANT = NRM_V256,
   parameter logic [15:0] RAM_KB = 16'h0008,
   // Arbitrary value
   parameter logic [95:0] DIE_SERIAL = 96'h0123_4567_89AB_CDEF_1357_9BDF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_addr,
   output logic fetch_ready,
   output logic [31:0] fetch_data,
   output logic [31:0] arr_addr,
   input wire logic [63:0] arr_rdata,
   input wire logic [127:0] opt_src,
   output logic [127:0] opt_ctrl,
   output logic op_valid,
   output nrm_op_t op
);
   // R20 geometry from variant
   localparam int PSHIFT = nrm_page_shift(VARIANT);
   localparam int PCOUNT = nrm_page_count(VARIANT);
   localparam bit WIDE = (VARIANT == NRM_VDW128);
   // R4 main array size in kilobytes
   localparam logic [15:0] MAIN_KB = 16'((PCOUNT << PSHIFT) >> 10);
   initial begin
      if (VARIANT < NRM_V256 || VARIANT > NRM_VDW128) begin
         $error("nrm_region_map: unknown variant");
      end
   end
   typedef enum logic [1:0] {FS_IDLE, FS_WAIT, FS_PREF} nrm_fstate_t;
   logic aw_full_reg;
   logic [31:0] aw_addr_reg;
   logic w_full_reg;
   logic [31:0] w_data_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [1:0] ws_reg;
   logic pf_en_reg;
   logic [31:0] taddr_reg;
   logic [31:0] dlo_reg;
   logic [31:0] dhi_reg;
   logic reject_reg;
   logic opt_loaded_reg;
   logic [127:0] opt_reg;
   logic op_valid_reg;
   nrm_op_t op_reg;
   nrm_fstate_t fstate_reg;
   logic [1:0] wcnt_reg;
   logic [28:0] cur_tag_reg;
   logic cur_ok_reg;
   logic [63:0] cur_reg;
   logic [28:0] pf_tag_reg;
   logic pf_ok_reg;
   logic [63:0] pf_reg;
   logic [31:0] arr_addr_reg;
   logic fresp_reg;
   logic [31:0] fdata_reg;
   wire logic do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   wire logic wr_wait = (aw_addr_reg == NRM_WAIT_ADDR);
   wire logic wr_cmd = (aw_addr_reg == NRM_CMD_ADDR);
   wire logic wr_taddr = (aw_addr_reg == NRM_TADDR_ADDR);
   wire logic wr_dlo = (aw_addr_reg == NRM_DLO_ADDR);
   wire logic wr_dhi = (aw_addr_reg == NRM_DHI_ADDR);
   wire logic wr_stat = (aw_addr_reg == NRM_STAT_ADDR);
   wire logic wr_ok = wr_wait || wr_cmd || wr_taddr || wr_dlo || wr_dhi || wr_stat;
   logic t_main;
   logic [7:0] t_page;
   logic t_boot;
   logic t_otp;
   nrm_page_decode #(
      .PAGE_SHIFT(PSHIFT),
      .PAGE_COUNT(PCOUNT),
      .WIDE_FAMILY(WIDE)
   ) u_tdec (
      .addr(taddr_reg),
      .in_main(t_main),
      .page(t_page),
      .in_boot(t_boot),
      .in_opt(),
      .in_otp(t_otp)
   );
   wire nrm_op_kind_t cmd_kind = nrm_op_kind_t'(w_data_reg[1:0]);
   // R18 program unit alignment
   wire logic aligned = WIDE ? (taddr_reg[2:0] == 3'h0) : (taddr_reg[1:0] == 2'h0);
   // R13 R14 R18 legal targets
   wire logic cmd_legal = !t_boot && (
      (cmd_kind == NRM_OP_PAGE_ERASE && t_main) ||
      (cmd_kind == NRM_OP_MASS_ERASE) ||
      (cmd_kind == NRM_OP_PROGRAM && aligned && (t_main || t_otp)));
   wire logic cmd_fire = do_write && wr_cmd && cmd_kind != NRM_OP_NONE;
   wire logic issue = cmd_fire && cmd_legal;
   wire logic reject_set = cmd_fire && !cmd_legal;
   wire logic reject_clr = do_write && wr_stat && w_data_reg[NRM_REJ_BIT];
   // R1 R3 R4 R5 R6 R7 signature words
   wire logic [31:0] size_word = {RAM_KB, MAIN_KB};
   wire logic [1:0] opt_idx = s_axi_araddr[3:2];
   wire logic rd_optr = (s_axi_araddr >= NRM_OPTR_ADDR) && (s_axi_araddr <= NRM_OPTR_LAST)
      && (s_axi_araddr[1:0] == 2'h0);
   logic [31:0] rd_val;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (s_axi_araddr)
         NRM_SIZE_ADDR: rd_val = size_word;
         NRM_SER_LO_ADDR: rd_val = DIE_SERIAL[31:0];
         NRM_SER_MID_ADDR: rd_val = DIE_SERIAL[63:32];
         NRM_SER_HI_ADDR: rd_val = DIE_SERIAL[95:64];
         NRM_WAIT_ADDR: rd_val = {27'h0, pf_en_reg, 2'h0, ws_reg};
         NRM_TADDR_ADDR: rd_val = taddr_reg;
         NRM_DLO_ADDR: rd_val = dlo_reg;
         NRM_DHI_ADDR: rd_val = dhi_reg;
         NRM_STAT_ADDR: rd_val = {31'h0, reject_reg};
         default: begin
            rd_hit = rd_optr;
            rd_val = rd_optr ? opt_reg[32 * opt_idx +: 32] : 32'h0000_0000;
         end
      endcase
   end
   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready = !w_full_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         bvalid_reg <= 1'b0;
         bresp_reg <= NRM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end
         if (do_write) begin
            // R1 read-only locations refused
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? NRM_RESP_OKAY : NRM_RESP_SLVERR;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= NRM_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_val;
         rresp_reg <= rd_hit ? NRM_RESP_OKAY : NRM_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ws_reg <= NRM_WS_RESET;
         pf_en_reg <= NRM_PF_RESET;
         taddr_reg <= 32'h0000_0000;
         dlo_reg <= 32'h0000_0000;
         dhi_reg <= 32'h0000_0000;
         reject_reg <= 1'b0;
      end else begin
         // R17 wait state setting
         if (do_write && wr_wait) begin
            ws_reg <= w_data_reg[NRM_WS_LSB +: 2];
            pf_en_reg <= w_data_reg[NRM_PF_BIT];
         end
         if (do_write && wr_taddr) begin
            taddr_reg <= w_data_reg;
         end
         if (do_write && wr_dlo) begin
            dlo_reg <= w_data_reg;
         end
         if (do_write && wr_dhi) begin
            dhi_reg <= w_data_reg;
         end
         // R14 sticky reject, set wins
         reject_reg <= reject_set || (reject_reg && !reject_clr);
      end
   end
   // R15 option copy after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt_loaded_reg <= 1'b0;
         opt_reg <= 128'h0;
      end else if (!opt_loaded_reg) begin
         opt_loaded_reg <= 1'b1;
         opt_reg <= opt_src;
      end
   end
   assign opt_ctrl = opt_reg;
   // R13 R18 operation issue
   wire nrm_op_t op_next = '{cmd_kind, taddr_reg, t_page, {dhi_reg, dlo_reg}, WIDE};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_valid_reg <= 1'b0;
         op_reg <= '0;
      end else begin
         op_valid_reg <= issue;
         if (issue) begin
            op_reg <= op_next;
         end
      end
   end
   assign op_valid = op_valid_reg;
   assign op = op_reg;
   wire logic [28:0] f_tag = fetch_addr[31:3];
   wire logic cur_hit = cur_ok_reg && (cur_tag_reg == f_tag);
   wire logic pf_hit = pf_ok_reg && (pf_tag_reg == f_tag);
   wire logic f_take = fetch_valid && !fresp_reg && fstate_reg == FS_IDLE;
   wire logic [63:0] pick_src = (fstate_reg == FS_WAIT) ? arr_rdata : (cur_hit ? cur_reg : pf_reg);
   wire logic [31:0] pick = fetch_addr[2] ? pick_src[63:32] : pick_src[31:0];
   wire logic [31:0] next_dw = {fetch_addr[31:3] + 29'h1, 3'h0};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fstate_reg <= FS_IDLE;
         wcnt_reg <= 2'h0;
         cur_tag_reg <= 29'h0;
         cur_ok_reg <= 1'b0;
         cur_reg <= 64'h0;
         pf_tag_reg <= 29'h0;
         pf_ok_reg <= 1'b0;
         pf_reg <= 64'h0;
         arr_addr_reg <= 32'h0000_0000;
         fresp_reg <= 1'b0;
         fdata_reg <= 32'h0000_0000;
      end else begin
         fresp_reg <= 1'b0;
         unique case (fstate_reg)
            FS_IDLE: begin
               if (f_take && cur_hit) begin
                  fresp_reg <= 1'b1;
                  fdata_reg <= pick;
               end else if (f_take && pf_hit) begin
                  // R19 promote and fetch ahead
                  fresp_reg <= 1'b1;
                  fdata_reg <= pick;
                  cur_reg <= pf_reg;
                  cur_tag_reg <= pf_tag_reg;
                  cur_ok_reg <= 1'b1;
                  pf_ok_reg <= 1'b0;
                  arr_addr_reg <= next_dw;
                  wcnt_reg <= ws_reg;
                  fstate_reg <= FS_PREF;
               end else if (f_take) begin
                  // R17 miss waits configured states
                  arr_addr_reg <= {f_tag, 3'h0};
                  wcnt_reg <= ws_reg;
                  fstate_reg <= FS_WAIT;
               end
            end
            FS_WAIT: begin
               if (wcnt_reg == 2'h0) begin
                  fresp_reg <= 1'b1;
                  fdata_reg <= pick;
                  cur_reg <= arr_rdata;
                  cur_tag_reg <= f_tag;
                  cur_ok_reg <= 1'b1;
                  pf_ok_reg <= 1'b0;
                  if (pf_en_reg) begin
                     arr_addr_reg <= next_dw;
                     wcnt_reg <= ws_reg;
                     fstate_reg <= FS_PREF;
                  end else begin
                     fstate_reg <= FS_IDLE;
                  end
               end else begin
                  wcnt_reg <= wcnt_reg - 2'h1;
               end
            end
            FS_PREF: begin
               if (wcnt_reg == 2'h0) begin
                  pf_reg <= arr_rdata;
                  pf_tag_reg <= arr_addr_reg[31:3];
                  pf_ok_reg <= 1'b1;
                  fstate_reg <= FS_IDLE;
               end else begin
                  wcnt_reg <= wcnt_reg - 2'h1;
               end
            end
         endcase
         // Buffers dropped when the array changes
         if (issue) begin
            cur_ok_reg <= 1'b0;
            pf_ok_reg <= 1'b0;
         end
      end
   end
   assign fetch_ready = fresp_reg;
   assign fetch_data = fdata_reg;
   assign arr_addr = arr_addr_reg;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sig_write_refused_a: assert property ( // R1
      do_write && (aw_addr_reg[31:4] == NRM_SIZE_ADDR[31:4])
      |=> s_axi_bvalid && s_axi_bresp == NRM_RESP_SLVERR)
      else $error("signature write accepted");
   size_word_read_a: assert property ( // R3
      s_axi_arvalid && s_axi_arready && s_axi_araddr == NRM_SIZE_ADDR
      |=> s_axi_rdata[31:16] == RAM_KB && s_axi_rdata[15:0] == MAIN_KB)
      else $error("size word wrong");
   serial_low_read_a: assert property ( // R5
      s_axi_arvalid && s_axi_arready && s_axi_araddr == NRM_SER_LO_ADDR
      |=> s_axi_rvalid && s_axi_rdata == DIE_SERIAL[31:0])
      else $error("serial low word wrong");
   serial_high_read_a: assert property ( // R7
      s_axi_arvalid && s_axi_arready && s_axi_araddr == NRM_SER_HI_ADDR
      |=> s_axi_rdata == DIE_SERIAL[95:64])
      else $error("serial high word wrong");
   boot_target_reject_a: assert property ( // R14
      cmd_fire && t_boot |=> !op_valid && reject_reg)
      else $error("boot range operation issued");
   page_erase_index_a: assert property ( // R13
      cmd_fire && cmd_kind == NRM_OP_PAGE_ERASE && t_main
      |=> op_valid && op.page == $past(taddr_reg[PSHIFT +: 8]))
      else $error("page erase index wrong");
   option_copy_a: assert property ( // R15
      $rose(aresetn) |=> opt_ctrl == $past(opt_src))
      else $error("option region not copied");
   miss_wait_count_a: assert property ( // R17
      f_take && !cur_hit && !pf_hit && ws_reg == 2'h2 |=> !fetch_ready [*3] ##1 fetch_ready)
      else $error("wait states not applied");
   prefetch_start_a: assert property ( // R19
      fstate_reg == FS_WAIT && wcnt_reg == 2'h0 && pf_en_reg
      |=> fstate_reg == FS_PREF && arr_addr == $past(arr_addr) + 32'h8)
      else $error("prefetch not started");
   cov_pf_hit: cover property (f_take && pf_hit);
   cov_issue: cover property (issue);
   cov_reject: cover property (reject_set);
   cov_ser_mid: cover property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == NRM_SER_MID_ADDR);
endmodule // nrm_region_map

/* File: core/nrm_pkg.sv */
// Constants, types and address map of the nonvolatile region map block
// Functional notes
// R1: Signature words are fixed constants; writes never change them.
// R2: Reader accesses each signature word only as a full 32-bit word.
// R3: Size word upper half returns on-chip RAM capacity in kilobytes.
// R4: Size word lower half returns main array capacity in kilobytes.
// R5: First serial location returns die serial bits 31 to 0.
// R6: Second serial location returns die serial bits 63 to 32.
// R7: Following location returns die serial bits 95 to 64.
// R8: Largest variant decodes 64 pages of 4 kilobytes from array base.
// R9: 128-kilobyte word variant decodes 64 pages of 2 kilobytes.
// R10: 64-kilobyte variant decodes 64 pages of 1 kilobyte.
// R11: 32-kilobyte variant decodes 32 pages of 1 kilobyte.
// R12: Double-word family uses 128 pages of 1 kilobyte, 12-kilobyte info block.
// R13: Any single main page may be erased alone.
// R14: Boot loader range is mapped; user program or erase there is rejected.
// R15: 16-byte option region is copied into option registers at every reset.
// R16: 512-byte one-time user block is mapped at its base.
// R17: Array fetches take zero to three configured wait states.
// R18: Word or double-word programming per family; page and mass erase on both.
// R19: Prefetch buffer fetches the next double word on sequential reads.
// R20: Page size and count follow a fixed density variant parameter.
package nrm_pkg;
   // Density variants
   localparam int NRM_V256 = 0;
   localparam int NRM_V128 = 1;
   localparam int NRM_V64 = 2;
   localparam int NRM_V32 = 3;
   localparam int NRM_VDW128 = 4;
   // Region map
   localparam logic [31:0] NRM_MAIN_BASE = 32'h0800_0000;
   localparam logic [31:0] NRM_BOOT_BASE = 32'h1FFF_D000;
   localparam logic [31:0] NRM_BOOT_LAST = 32'h1FFF_F7FF;
   localparam logic [31:0] NRM_DWINFO_BASE = 32'h1FFF_C800;
   localparam logic [31:0] NRM_OPT_BASE = 32'h1FFF_F800;
   localparam logic [31:0] NRM_OPT_LAST = 32'h1FFF_F80F;
   localparam logic [31:0] NRM_OTP_BASE = 32'h1FFF_7000;
   localparam logic [31:0] NRM_OTP_LAST = 32'h1FFF_71FF;
   // Signature words
   localparam logic [31:0] NRM_SIZE_ADDR = 32'h1FFF_F7E0;
   localparam logic [31:0] NRM_SER_LO_ADDR = 32'h1FFF_F7E8;
   localparam logic [31:0] NRM_SER_MID_ADDR = 32'h1FFF_F7EC;
   localparam logic [31:0] NRM_SER_HI_ADDR = 32'h1FFF_F7F0;
   localparam int NRM_RAM_KB_LSB = 16;
   // Control registers
   localparam logic [31:0] NRM_WAIT_ADDR = 32'h4002_2000;
   localparam logic [31:0] NRM_CMD_ADDR = 32'h4002_2004;
   localparam logic [31:0] NRM_TADDR_ADDR = 32'h4002_2008;
   localparam logic [31:0] NRM_DLO_ADDR = 32'h4002_200C;
   localparam logic [31:0] NRM_DHI_ADDR = 32'h4002_2010;
   localparam logic [31:0] NRM_STAT_ADDR = 32'h4002_2014;
   localparam logic [31:0] NRM_OPTR_ADDR = 32'h4002_2020;
   localparam logic [31:0] NRM_OPTR_LAST = 32'h4002_202C;
   localparam int NRM_WS_LSB = 0;
   localparam int NRM_PF_BIT = 4;
   localparam int NRM_REJ_BIT = 0;
   localparam logic [1:0] NRM_WS_RESET = 2'h0;
   localparam logic NRM_PF_RESET = 1'b0;
   localparam logic [1:0] NRM_RESP_OKAY = 2'h0;
   localparam logic [1:0] NRM_RESP_SLVERR = 2'h2;
   // Operation codes in command register
   typedef enum logic [1:0] {
      NRM_OP_NONE,
      NRM_OP_PAGE_ERASE,
      NRM_OP_MASS_ERASE,
      NRM_OP_PROGRAM
   } nrm_op_kind_t;
   typedef struct packed {
      nrm_op_kind_t kind;
      logic [31:0] addr;
      logic [7:0] page;
      logic [63:0] data;
      logic wide;
   } nrm_op_t;
   // Page geometry per variant
   function automatic int nrm_page_shift(int v);
      case (v)
         NRM_V256: return 12;
         NRM_V128: return 11;
         default: return 10;
      endcase
   endfunction
   function automatic int nrm_page_count(int v);
      case (v)
         NRM_V32: return 32;
         NRM_VDW128: return 128;
         default: return 64;
      endcase
   endfunction
endpackage

/* File: core/nrm_page_decode.sv */
// Address to region and page decoder
`timescale 1ns/10ps
module nrm_page_decode
   import nrm_pkg::*;
#(
   parameter int PAGE_SHIFT = 12,
   parameter int PAGE_COUNT = 64,
   parameter bit WIDE_FAMILY = 1'b0
) (
   input wire logic [31:0] addr,
   output logic in_main,
   output logic [7:0] page,
   output logic in_boot,
   output logic in_opt,
   output logic in_otp
);
   localparam logic [31:0] MAIN_SIZE = 32'(PAGE_COUNT) << PAGE_SHIFT;
   localparam logic [31:0] INFO_BASE = WIDE_FAMILY ? NRM_DWINFO_BASE : NRM_BOOT_BASE;
   wire logic [31:0] offset = addr - NRM_MAIN_BASE;
   initial begin
      if (PAGE_SHIFT < 10 || PAGE_SHIFT > 12 || PAGE_COUNT > 256 || PAGE_COUNT < 1) begin
         $error("nrm_page_decode: unsupported geometry");
      end
   end
   // R8 R9 R10 R11 R12 page index
   assign in_main = (addr >= NRM_MAIN_BASE) && (offset < MAIN_SIZE);
   assign page = 8'(offset >> PAGE_SHIFT);
   // R14 boot loader range
   assign in_boot = (addr >= INFO_BASE) && (addr <= NRM_BOOT_LAST);
   // R15 R16 option and one-time regions
   assign in_opt = (addr >= NRM_OPT_BASE) && (addr <= NRM_OPT_LAST);
   assign in_otp = (addr >= NRM_OTP_BASE) && (addr <= NRM_OTP_LAST);
endmodule // nrm_page_decode

/* File: dv/nrm_array_model.sv */
// Array read model that serves a double word after the wait states
`timescale 1ns/10ps
module nrm_array_model #(
   parameter int WS = 2
) (
   input wire logic aclk,
   input wire logic [31:0] arr_addr,
   output logic [63:0] arr_rdata
);
   localparam logic [63:0] GOOD = 64'hC3C3_9876_5A5A_1234;
   logic [31:0] last_addr = '0;
   int cnt = 0;
   always @(posedge aclk) begin
      last_addr <= arr_addr;
      cnt <= (arr_addr != last_addr) ? 1 : cnt + 1;
   end
   assign arr_rdata = (arr_addr == last_addr && cnt >= WS) ? (GOOD ^ {2{arr_addr}}) : ~GOOD;
endmodule // nrm_array_model

/* File: dv/nrm_region_map_tb.sv */
// Signature, command and fetch tests for the region map
`timescale 1ns/10ps
module nrm_region_map_tb;
   import nrm_pkg::*;
   // Arbitrary serial value
   localparam logic [95:0] SER = 96'hA1B2_C3D4_E5F6_0718_293A_4B5C;
   localparam logic [127:0] OPT = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
   localparam logic [31:0] SIZE = {16'h0008, 16'h0100};
   localparam int WS = 2;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, fetch_addr = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, fetch_valid = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic fetch_ready, op_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, fetch_data, arr_addr, rd;
   logic [63:0] arr_rdata;
   logic [127:0] opt_ctrl;
   nrm_op_t op, last_op;
   logic [31:0] tad [4] = '{32'h0803_F000, 32'h1FFF_D000, 32'h0800_0000, 32'h0800_0004};
   nrm_op_kind_t kd [4] = '{NRM_OP_PAGE_ERASE, NRM_OP_PROGRAM, NRM_OP_MASS_ERASE, NRM_OP_PROGRAM};
   int failures = 0, compares = 0, op_cnt = 0, cycles = 0, n;
   always #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (op_valid) begin
         last_op <= op;
         op_cnt <= op_cnt + 1;
      end
   end
   nrm_region_map #(.VARIANT(NRM_V256), .RAM_KB(16'h0008), .DIE_SERIAL(SER)) i_nrm_region_map (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .fetch_ready(fetch_ready), .fetch_data(fetch_data), .arr_addr(arr_addr),
      .arr_rdata(arr_rdata), .opt_src(OPT), .opt_ctrl(opt_ctrl), .op_valid(op_valid), .op(op)
   );
   nrm_array_model #(.WS(WS)) i_nrm_array_model (
      .aclk(aclk), .arr_addr(arr_addr), .arr_rdata(arr_rdata)
   );
   task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
      chk_word(nm, {30'h0, exp}, {30'h0, got});
   endtask
   task automatic wrap_up;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, hit;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hit = 1'b0;
      while (!hit) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         hit = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, hit;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hit = 1'b0;
      while (!hit) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         hit = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic fetch(input logic [31:0] a, output logic [31:0] d, output int c);
      fetch_addr <= a;
      fetch_valid <= 1'b1;
      c = 0;
      do begin
         @(negedge aclk);
         c++;
      end while (!fetch_ready);
      d = fetch_data;
      @(posedge aclk);
      fetch_valid <= 1'b0;
   endtask
   initial begin
      wait (cycles == 3000);
      failures++;
      wrap_up();
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 4; i++) chk_word("option copy", OPT[32*i +: 32], opt_ctrl[32*i +: 32]);
      axi_read(NRM_SIZE_ADDR, rd, resp);
      chk_word("size word", SIZE, rd);
      axi_read(NRM_SER_LO_ADDR, rd, resp);
      chk_word("serial low", SER[31:0], rd);
      axi_read(NRM_SER_MID_ADDR, rd, resp);
      chk_word("serial mid", SER[63:32], rd);
      axi_read(NRM_SER_HI_ADDR, rd, resp);
      chk_word("serial high", SER[95:64], rd);
      axi_write(NRM_SIZE_ADDR, 32'hFFFF_FFFF, resp);
      chk_resp("size write resp", NRM_RESP_SLVERR, resp);
      axi_read(NRM_SIZE_ADDR, rd, resp);
      chk_word("size after write", SIZE, rd);
      axi_read(32'h1FFF_F7E4, rd, resp);
      chk_resp("unmapped resp", NRM_RESP_SLVERR, resp);
      $display("test signature done");
      axi_write(NRM_DLO_ADDR, 32'h1357_2468, resp);
      for (int i = 0; i < 4; i++) begin
         n = op_cnt;
         axi_write(NRM_TADDR_ADDR, tad[i], resp);
         axi_write(NRM_CMD_ADDR, {30'h0, kd[i]}, resp);
         chk_resp("command resp", NRM_RESP_OKAY, resp);
         chk_word("op count", 32'(n + (i != 1)), 32'(op_cnt));
         if (i != 1) chk_word("op kind", {30'h0, kd[i]}, {30'h0, last_op.kind});
         if (i == 0) chk_word("op page", 32'h0000_003F, {24'h0, last_op.page});
         if (i == 3) chk_word("op addr", tad[3], last_op.addr);
         if (i == 3) chk_word("op data low", 32'h1357_2468, last_op.data[31:0]);
      end
      axi_read(NRM_STAT_ADDR, rd, resp);
      chk_word("reject flag", 32'h0000_0001, rd & 32'h0000_0001);
      axi_write(NRM_STAT_ADDR, 32'h0000_0001, resp);
      axi_read(NRM_STAT_ADDR, rd, resp);
      chk_word("reject cleared", 32'h0000_0000, rd & 32'h0000_0001);
      $display("test command done");
      axi_write(NRM_WAIT_ADDR, 32'(WS) | (32'h0000_0001 << NRM_PF_BIT), resp);
      fetch(32'h0800_0004, rd, n);
      chk_word("fetch data", 32'hCBC3_9876, rd);
      chk_word("fetch latency", 32'(WS + 3), 32'(n));
      repeat (WS + 2) @(posedge aclk);
      fetch(32'h0800_0008, rd, n);
      chk_word("prefetch data", 32'h525A_123C, rd);
      chk_word("prefetch latency", 32'h0000_0002, 32'(n));
      $display("test fetch done");
      wrap_up();
   end
endmodule // nrm_region_map_tb
